// File: src/mrad_decode.sv
// address placement and decode for module registers and pseudolinear space
// Function
// - register nibble is map bit then 111
// - bus bits 23:20 copy address bit 19
// - processor never reaches 080000 to f7ffff
// - cleared map bit moves registers to 700000
// - standby ram placed by its base register
// - absent module blocks go to external bus
// - vectors fetched from bank 0 only
// - vectors are 16-bit, jump table in bank 0
// - pc, sp and z take any 20-bit address
`timescale 1ns/1ps
module mrad_decode import mrad_pkg::*; #(
	parameter logic [15:0] IMPL_MASK = IMPL_MASK_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration writes from the integration block
	input wire logic mapBitWrEn,
	input wire logic mapBitWrVal,
	input wire logic ramBaseWrEn,
	input wire logic [10:0] ramBaseWrVal,
	// processor request
	input wire mrad_req_t req,
	input wire logic [2:0] spaceCode,
	// decoded result
	output mrad_dest_t dest_q,
	output logic destValid_q,
	output logic [2:0] space_code_outputs_q,
	output logic blocked_q,
	output logic module_map_bit_q
);
	// ==========================================
	// overview
	// the processor drives 20 address bits and the bus carries 24, so the
	// top four repeat bit 19; the processor therefore only ever sees the
	// lowest and the highest half megabyte of the bus space. module registers
	// sit in a 4 kbyte window whose upper nibble is the map bit over 111,
	// so clearing the bit parks them where no processor address can reach.
	// every answer is registered and stands for exactly one cycle, which
	// costs a cycle of latency but keeps the outputs free of decode glitches.
	// ==========================================
	// configuration state
	logic mapBit_q; // module map bit of the config register
	logic mapLocked_q; // once cleared, software can no longer reach it
	logic [10:0] ramBase_q; // standby ram base, address bits 21:11
	logic [BUS_AW-1:0] extAddr; // extended bus address
	logic [3:0] regNibble; // register base nibble
	logic hitModule; // address falls in an implemented module slot
	logic hitRam; // address falls in the standby ram block
	logic vectorOk; // not a vector, or a vector from bank 0
	mrad_dest_t dest_d; // destination before the output register

	// upper bit replication lives in its own module, instanced here as uExt
	mrad_extend uExt (
		.cpuAddr(req.addr),
		.busAddr(extAddr)
	);

	// ==========================================
	// map bit: set at reset, writable only while registers still reachable
	always_ff @(posedge clk) begin
		if (rst) begin
			// reset brings the registers back at the upper base
			mapBit_q <= MAP_BIT_RESET;
			mapLocked_q <= 1'h0;
		end else if (mapBitWrEn && !mapLocked_q) begin
			// clearing hides the registers, so no later write can undo it
			mapBit_q <= mapBitWrVal;
			mapLocked_q <= !mapBitWrVal;
		end
	end

	// ==========================================
	// standby ram base register
	always_ff @(posedge clk) begin
		if (rst) begin
			ramBase_q <= RAM_BASE_RESET;
		end else if (ramBaseWrEn) begin
			// no fixed home: the array goes wherever software points it
			ramBase_q <= ramBaseWrVal;
		end
	end

	// ==========================================
	// combinational decode
	always_comb begin
		regNibble = {mapBit_q, REG_NIBBLE_LOW};
		// module window: 4 kbyte at nibble:ff000; absent slots fall outside
		hitModule = (extAddr[23:20] == regNibble) && (extAddr[19:12] == MOD_PAGE)
			&& IMPL_MASK[extAddr[11:8]];
		// ram: 2 kbyte block compared on address bits 23:11
		// the base register spans bits 21:11 only, so the array stays low
		hitRam = (extAddr[23:11] == {2'h0, ramBase_q});
		// vectors come from bank 0 only, 16-bit handler pointers
		vectorOk = !req.isVector || (req.addr[19:16] == VECTOR_BANK);
		dest_d.busAddr = req.isVector ? {8'h00, req.addr[BANK_AW-1:0]} : extAddr;
		dest_d.toModule = req.valid && vectorOk && hitModule;
		dest_d.toRam = req.valid && vectorOk && !hitModule && hitRam;
		// every other accepted request, including absent blocks, runs on the external bus
		dest_d.toExternal = req.valid && vectorOk && !hitModule && !hitRam;
	end

	// ==========================================
	// registered outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			// every output except module_map_bit_q idles low while reset is held
			dest_q <= '0;
			destValid_q <= 1'h0;
			space_code_outputs_q <= 3'h0;
			blocked_q <= 1'h0;
		end else begin
			// refused vectors raise blocked and carry no destination
			dest_q <= dest_d;
			destValid_q <= req.valid && vectorOk;
			space_code_outputs_q <= spaceCode;
			blocked_q <= req.valid && !vectorOk;
		end
	end

	// map bit visible to the rest of the chip
	// one cycle behind the internal bit, in step with the other outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			module_map_bit_q <= MAP_BIT_RESET;
		end else begin
			module_map_bit_q <= mapBit_q;
		end
	end

	// ==========================================
	// checks
	// address formation
	// the top nibble must always repeat bit 19 for ordinary accesses
	upper_copy_a: assert property (@(posedge clk) disable iff (rst)
		destValid_q && !$past(req.isVector) |->
		dest_q.busAddr[23:20] == {4{dest_q.busAddr[19]}})
		else $error("upper bits do not follow bit 19");
	// nothing accepted may land in the unreachable middle of the bus space
	hole_never_a: assert property (@(posedge clk) disable iff (rst)
		destValid_q |-> !(dest_q.busAddr >= UNREACH_LO && dest_q.busAddr <= UNREACH_HI))
		else $error("address inside unreachable range");
	// the same holds for the extended address before it is registered
	hole_comb_a: assert property (@(posedge clk) disable iff (rst)
		req.valid && !req.isVector |-> !(extAddr >= UNREACH_LO && extAddr <= UNREACH_HI))
		else $error("extended address inside unreachable range");
	// ordinary accesses pass all 20 processor bits through untouched
	full_range_a: assert property (@(posedge clk) disable iff (rst)
		req.valid && !req.isVector |=> dest_q.busAddr[19:0] == $past(req.addr))
		else $error("20-bit address altered");
	// map bit
	// reset must leave the registers reachable at once
	map_reset_a: assert property (@(posedge clk) $fell(rst) |-> mapBit_q)
		else $error("map bit not set after reset");
	// a cleared bit stays cleared until the next reset
	map_sticky_a: assert property (@(posedge clk) disable iff (rst)
		!mapBit_q |=> !mapBit_q)
		else $error("cleared map bit came back without reset");
	// while the bit is still set, a write takes the written value
	map_write_a: assert property (@(posedge clk) disable iff (rst)
		mapBitWrEn && mapBit_q |=> mapBit_q == $past(mapBitWrVal))
		else $error("map bit write not taken");
	// with the bit cleared the register nibble is the lower base
	cleared_base_a: assert property (@(posedge clk) disable iff (rst)
		!mapBit_q |-> regNibble == REG_BASE_CLEARED[23:20])
		else $error("cleared map bit not at lower base");
	// the visible copy trails the internal bit by one cycle
	map_copy_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) |-> module_map_bit_q == $past(mapBit_q))
		else $error("visible map bit does not follow");
	// destinations
	// a module hit carries the nibble built from the map bit
	nibble_form_a: assert property (@(posedge clk) disable iff (rst)
		$past(req.valid) && dest_q.toModule |-> dest_q.busAddr[22:20] == REG_NIBBLE_LOW
		&& dest_q.busAddr[23] == $past(mapBit_q))
		else $error("module hit with wrong base nibble");
	// the processor never reaches the moved register window
	cleared_unreach_a: assert property (@(posedge clk) disable iff (rst)
		!$past(mapBit_q) |-> !dest_q.toModule)
		else $error("registers reached with map bit cleared");
	// absent module slots are sent to the external bus
	absent_ext_a: assert property (@(posedge clk) disable iff (rst)
		req.valid && !req.isVector && extAddr[23:12] == {regNibble, MOD_PAGE}
		&& !IMPL_MASK[extAddr[11:8]] && !hitRam |=> dest_q.toExternal)
		else $error("absent block not sent external");
	// an accepted request goes to exactly one place
	dest_onehot_a: assert property (@(posedge clk) disable iff (rst)
		destValid_q |-> $onehot({dest_q.toModule, dest_q.toRam, dest_q.toExternal}))
		else $error("request sent to no place or to several");
	// the ram answers at whatever base software wrote
	ram_place_a: assert property (@(posedge clk) disable iff (rst)
		req.valid && !req.isVector && !hitModule && extAddr[23:11] == {2'h0, ramBase_q}
		|=> dest_q.toRam)
		else $error("ram not at its base register");
	// a base write lands on the next edge
	ram_write_a: assert property (@(posedge clk) disable iff (rst)
		ramBaseWrEn |=> ramBase_q == $past(ramBaseWrVal))
		else $error("ram base write not taken");
	// space codes pass through with one cycle of delay
	space_code_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) |-> space_code_outputs_q == $past(spaceCode))
		else $error("space code not passed through");
	// vectors
	// a vector outside bank 0 is refused
	vector_bank_a: assert property (@(posedge clk) disable iff (rst)
		req.valid && req.isVector && req.addr[19:16] != VECTOR_BANK |=>
		blocked_q && !destValid_q)
		else $error("vector fetched outside bank 0");
	// a refused vector carries no destination at all
	blocked_clean_a: assert property (@(posedge clk) disable iff (rst)
		blocked_q |-> !destValid_q && !dest_q.toModule
		&& !dest_q.toRam && !dest_q.toExternal)
		else $error("refused vector still has a destination");
	// vector pointers are 16 bits wide
	vector_width_a: assert property (@(posedge clk) disable iff (rst)
		req.valid && req.isVector |=> dest_q.busAddr[23:16] == 8'h00)
		else $error("vector address wider than 16 bits");
	// a bank 0 vector is accepted with its low 16 bits intact
	vector_keep_a: assert property (@(posedge clk) disable iff (rst)
		req.valid && req.isVector && req.addr[19:16] == VECTOR_BANK |=>
		destValid_q && !blocked_q && dest_q.busAddr[15:0] == $past(req.addr[15:0]))
		else $error("bank 0 vector not passed intact");
	// coverage of the main scenarios
	// a register access that lands on a module slot
	cov_module_c: cover property (@(posedge clk) dest_q.toModule);
	// a standby ram access
	cov_ram_c: cover property (@(posedge clk) dest_q.toRam);
	// an access passed to the external bus
	cov_ext_c: cover property (@(posedge clk) dest_q.toExternal);
	// software hiding the registers until reset
	cov_clear_c: cover property (@(posedge clk) $fell(mapBit_q));
	// a vector refused for lying outside bank 0
	cov_block_c: cover property (@(posedge clk) blocked_q);
endmodule

// File: src/mrad_pkg.sv
// package for the module register address decode block
package mrad_pkg;
	// ==========================================
	// address widths
	localparam int CPU_AW = 20;
	localparam int BUS_AW = 24;
	localparam int MOD_SPAN_AW = 12;
	localparam int BANK_AW = 16;
	localparam int BANK_MSB = 19;
	// ==========================================
	// register base and reachability limits
	localparam logic [2:0] REG_NIBBLE_LOW = 3'h7;
	localparam logic [7:0] MOD_PAGE = 8'hff; // bus bits 19:12 of the module window
	localparam logic [23:0] UNREACH_LO = 24'h080000;
	localparam logic [23:0] UNREACH_HI = 24'hf7ffff;
	localparam logic [23:0] REG_BASE_CLEARED = 24'h700000;
	localparam logic MAP_BIT_RESET = 1'h1;
	localparam logic [3:0] VECTOR_BANK = 4'h0;
	// ==========================================
	// block presence mask defaults, one bit per 256-byte slot index
	localparam int SLOT_AW = 4;
	localparam logic [15:0] IMPL_MASK_DEF = 16'h00f3;
	localparam logic [10:0] RAM_BASE_RESET = 11'h000;
	// ==========================================
	// processor request
	typedef struct packed {
		logic valid;
		logic [19:0] addr;
		logic isVector;
	} mrad_req_t;
	// decoded destination
	typedef struct packed {
		logic toModule;
		logic toRam;
		logic toExternal;
		logic [23:0] busAddr;
	} mrad_dest_t;
endpackage

// File: src/mrad_extend.sv
// sign-style upper address extension of the 20-bit processor address
`timescale 1ns/1ps
module mrad_extend import mrad_pkg::*; (
	// processor side
	input wire logic [CPU_AW-1:0] cpuAddr,
	// bus side
	output logic [BUS_AW-1:0] busAddr
);
	// copy bit 19 into bits 23:20 so the bus never sees the hole
	always_comb begin
		busAddr = {{(BUS_AW-CPU_AW){cpuAddr[BANK_MSB]}}, cpuAddr};
	end
endmodule

// File: dv/mrad_cpu_model.sv
// processor core model that issues requests into the decoder
`timescale 1ns/1ps
module mrad_cpu_model import mrad_pkg::*; (
	// clock
	input wire logic clk,
	// request towards the decoder
	output mrad_req_t req,
	output logic [2:0] spaceCode
);
	// ==========
	// idle until the first request
	initial begin
		req = '0;
		spaceCode = 3'h0;
	end
	// one request for one cycle, launched off the falling edge
	task automatic send(input logic [19:0] a, input logic v, input logic [2:0] sc);
		@(negedge clk);
		req <= '{valid: 1'h1, addr: a, isVector: v};
		spaceCode <= sc;
		@(negedge clk);
		// idle lines show the inverse, so a stale value never passes as fresh
		req <= '{valid: 1'h0, addr: ~a, isVector: ~v};
		spaceCode <= ~sc;
	endtask
endmodule

// File: dv/mrad_decode_test.sv
// self-checking bench for the address decode block
`timescale 1ns/1ps
module mrad_decode_test;
	import mrad_pkg::*;
	// ==========
	// drives and observed outputs
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic mapWe = 1'h0;
	logic mapVal = 1'h1;
	logic ramWe = 1'h0;
	logic [10:0] ramVal = 11'h000;
	mrad_req_t req;
	logic [2:0] spaceCode;
	mrad_dest_t dest;
	logic destValid;
	logic blocked;
	logic mapBit;
	logic [2:0] codeOut;
	int errors = 0;
	int cmp_count = 0;
	always #5 clk = ~clk;
	mrad_cpu_model i_cpu (.clk(clk), .req(req), .spaceCode(spaceCode));
	mrad_decode i_dut (.clk(clk), .rst(rst), .mapBitWrEn(mapWe), .mapBitWrVal(mapVal),
		.ramBaseWrEn(ramWe), .ramBaseWrVal(ramVal), .req(req), .spaceCode(spaceCode),
		.dest_q(dest), .destValid_q(destValid), .space_code_outputs_q(codeOut),
		.blocked_q(blocked), .module_map_bit_q(mapBit));
	// ==========
	// shared helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// e is flags, bus address, accepted, refused
	task automatic look(input logic [19:0] a, input logic v, input logic [28:0] e);
		i_cpu.send(a, v, 3'h0);
		chk({3'h0, dest, destValid, blocked}, {3'h0, e});
	endtask
	task automatic wmap(input logic v);
		@(negedge clk);
		mapWe = 1'h1;
		mapVal = v;
		@(negedge clk);
		mapWe = 1'h0;
		// the visible copy lags one cycle
		@(negedge clk);
	endtask
	task automatic do_reset();
		rst = 1'h1;
		repeat (3) @(negedge clk);
		rst = 1'h0;
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		chk({destValid, blocked, codeOut, mapBit}, 6'h01);
	endtask
	task automatic t_map();
		look(20'hff000, 1'h0, {3'h4, 24'hfff000, 2'h2});
		look(20'hff100, 1'h0, {3'h4, 24'hfff100, 2'h2});
		look(20'hff200, 1'h0, {3'h1, 24'hfff200, 2'h2});
		look(20'hff800, 1'h0, {3'h1, 24'hfff800, 2'h2});
		look(20'h7ffff, 1'h0, {3'h1, 24'h07ffff, 2'h2});
		look(20'h80000, 1'h0, {3'h1, 24'hf80000, 2'h2});
	endtask
	task automatic t_vec();
		look(20'h00ffe, 1'h1, {3'h1, 24'h000ffe, 2'h2});
		i_cpu.send(20'hf0ffe, 1'h1, 3'h0);
		chk({dest.toModule, dest.toRam, dest.toExternal, destValid, blocked}, 5'h01);
	endtask
	task automatic t_ram();
		look(20'h00400, 1'h0, {3'h2, 24'h000400, 2'h2});
		@(negedge clk);
		ramWe = 1'h1;
		ramVal = 11'h001;
		@(negedge clk);
		ramWe = 1'h0;
		look(20'h00400, 1'h0, {3'h1, 24'h000400, 2'h2});
		look(20'h00800, 1'h0, {3'h2, 24'h000800, 2'h2});
	endtask
	task automatic t_codes();
		for (int i = 0; i < 8; i++) begin
			i_cpu.send(20'h12345, 1'h0, 3'(i));
			chk(codeOut, 32'(i));
		end
	endtask
	task automatic t_lock();
		wmap(1'h1);
		chk(mapBit, 1'h1);
		wmap(1'h0);
		chk(mapBit, 1'h0);
		look(20'hff000, 1'h0, {3'h1, 24'hfff000, 2'h2});
		wmap(1'h1);
		chk(mapBit, 1'h0);
		do_reset();
		chk(mapBit, 1'h1);
		look(20'hff000, 1'h0, {3'h4, 24'hfff000, 2'h2});
	endtask
	// ==========
	// verdict, the single exit
	task automatic conclude();
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		do_reset();
		t_reset();
		t_map();
		t_vec();
		t_ram();
		t_codes();
		t_lock();
		conclude();
	end
	// watchdog, far beyond the roughly 60 cycles the run needs
	initial begin
		#20000;
		errors++;
		conclude();
	end
endmodule
